/* core/sfwp_prot.sv */
// serial flash write-protection core: link front end and status guard
`timescale 1ns/1ns
module sfwp_prot
  import sfwp_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic reset_n,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic wp_n,
  // array engine side
  input wire logic array_busy,
  input wire logic array_erasing,
  output logic op_start,
  output logic [7:0] op_code,
  output logic [23:0] op_addr,
  output logic op_reject,
  output logic cmd_discard,
  output logic deep_sleep,
  output logic [15:0] status_word
);

  // ---------------- link clock domain ----------------
  logic first_ff;
  logic frame_tgl_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [31:0] hdr_ff;
  logic rd_lo_ff;
  logic rd_hi_ff;
  logic so_ff;
  logic so_oe_ff;
  logic [15:0] status_hold_ff;
  logic deep_sleep_ff;

  // marks the first edge of a frame; chip select high rearms it
  // reset arms it too, so the first frame after power-up is not lost
  always_ff @(posedge sclk or posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      first_ff <= 1'b1;
    end else if (cs_n) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  // toggle per frame tells the system side a frame really happened
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_tgl_ff <= 1'b0;
    end else if (first_ff) begin
      frame_tgl_ff <= ~frame_tgl_ff;
    end
  end

  // bit counter saturates so very long program frames stay harmless
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (first_ff) begin
      cnt_ff <= CNT_W'(1);
    end else if (cnt_ff != {CNT_W{1'b1}}) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // header shifter keeps the first four bytes only
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      hdr_ff <= '0;
    end else if (first_ff || cnt_ff < LEN_4B) begin
      hdr_ff <= {hdr_ff[30:0], si};
    end
  end

  // status read selection latched on the eighth bit
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_lo_ff <= 1'b0;
      rd_hi_ff <= 1'b0;
    end else if (first_ff) begin
      rd_lo_ff <= 1'b0;
      rd_hi_ff <= 1'b0;
    end else if (cnt_ff == LEN_1B - 12'd1) begin
      rd_lo_ff <= ~deep_sleep_ff && {hdr_ff[6:0], si} == OP_STATUS_RD_LO;
      rd_hi_ff <= ~deep_sleep_ff && {hdr_ff[6:0], si} == OP_STATUS_RD_HI;
    end
  end

  // data shifts out on the falling edge; byte repeats while clocked
  always_ff @(negedge sclk or posedge cs_n or negedge reset_n) begin
    if (!reset_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (cs_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (rd_lo_ff || rd_hi_ff) begin
      so_oe_ff <= 1'b1;
      so_ff <= rd_hi_ff ? status_hold_ff[4'd15 - {1'b0, cnt_ff[2:0]}]
                        : status_hold_ff[4'd7 - {1'b0, cnt_ff[2:0]}];
    end
  end

  assign so = so_ff;
  assign so_oe = so_oe_ff;

  // ---------------- system clock domain ----------------
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic cs_prev_ff;
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic wp_meta_ff;
  logic wp_sync_ff;
  sfwp_link_t link_ff;

  // pins and the frame toggle pass two flops before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      wp_meta_ff <= 1'b0;
      wp_sync_ff <= 1'b0;
    end else begin
      cs_meta_ff <= cs_n;
      cs_sync_ff <= cs_meta_ff;
      tgl_meta_ff <= frame_tgl_ff;
      tgl_sync_ff <= tgl_meta_ff;
      wp_meta_ff <= wp_n;
      wp_sync_ff <= wp_meta_ff;
    end
  end

  // command state machine starts in standby after power-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_ff <= LS_STANDBY;
      cs_prev_ff <= 1'b1;
      tgl_seen_ff <= 1'b0;
    end else begin
      cs_prev_ff <= cs_sync_ff;
      unique case (link_ff)
        LS_STANDBY: begin
          if (!cs_sync_ff) begin
            link_ff <= LS_ACTIVE;
          end
        end
        LS_ACTIVE: begin
          if (cs_sync_ff) begin
            link_ff <= LS_STANDBY;
            tgl_seen_ff <= tgl_sync_ff;
          end
        end
      endcase
    end
  end

  // link-side fields are quiet once chip select is seen high
  logic frame_end;
  logic [31:0] aligned;
  logic [7:0] cmd;
  logic [23:0] addr;
  assign frame_end = (link_ff == LS_ACTIVE) && cs_sync_ff
                     && (tgl_sync_ff != tgl_seen_ff);
  assign aligned = (cnt_ff >= LEN_4B) ? hdr_ff
                 : hdr_ff << (LEN_4B - cnt_ff);
  assign cmd = aligned[31:24];
  assign addr = aligned[23:0];

  // protection fields
  logic [4:0] bp_ff;
  logic [1:0] guard_ff;
  logic [2:0] lock_ff;
  logic cmp_ff;
  logic wel_ff;
  logic erase_sus_ff;
  logic prog_sus_ff;

  // guarded region decode
  logic prot_any;
  logic [18:0] prot_lo;
  logic [18:0] prot_hi;
  always_comb begin
    logic base_none;
    logic base_all;
    logic [4:0] lg;
    logic [18:0] size;
    base_none = 1'b0;
    base_all = 1'b0;
    lg = LG_BLOCK;
    if (!bp_ff[4]) begin
      base_none = bp_ff[2:0] == 3'h0;
      base_all = bp_ff[2];
      lg = LG_BLOCK + {3'h0, bp_ff[1:0]} - 5'd1;
    end else begin
      base_none = bp_ff[2:0] == 3'h0;
      base_all = bp_ff[2:0] == 3'h7;
      lg = bp_ff[2] ? LG_HALF_BLOCK : LG_SECTOR + {3'h0, bp_ff[1:0]} - 5'd1;
    end
    size = 19'h00001 << lg;
    if (base_none) begin
      prot_any = cmp_ff;
      prot_lo = '0;
      prot_hi = MEM_TOP;
    end else if (base_all) begin
      prot_any = ~cmp_ff;
      prot_lo = '0;
      prot_hi = MEM_TOP;
    end else if (!bp_ff[3]) begin
      // top region, complement is everything below it
      prot_any = 1'b1;
      prot_lo = cmp_ff ? '0 : MEM_TOP - size + 19'h00001;
      prot_hi = cmp_ff ? MEM_TOP - size : MEM_TOP;
    end else begin
      // bottom region, complement is everything above it
      prot_any = 1'b1;
      prot_lo = cmp_ff ? size : '0;
      prot_hi = cmp_ff ? MEM_TOP : size - 19'h00001;
    end
  end

  // target range of the command and its overlap with the guard
  logic [4:0] tgt_lg;
  logic [18:0] tgt_lo;
  logic [18:0] tgt_hi;
  logic tgt_hit;
  always_comb begin
    unique case (cmd)
      OP_SECTOR_WIPE: tgt_lg = LG_SECTOR;
      OP_HALF_BLOCK_WIPE: tgt_lg = LG_HALF_BLOCK;
      OP_BLOCK_WIPE: tgt_lg = LG_BLOCK;
      default: tgt_lg = LG_PAGE;
    endcase
    tgt_lo = addr[18:0] & ~((19'h00001 << tgt_lg) - 19'h00001);
    tgt_hi = tgt_lo | ((19'h00001 << tgt_lg) - 19'h00001);
    tgt_hit = prot_any && tgt_lo <= prot_hi && tgt_hi >= prot_lo;
  end

  // command classes and length checks
  logic is_array;
  logic is_chip;
  logic is_sec;
  logic is_single;
  logic len_ok;
  logic sec_locked;
  logic wr_allow;
  assign is_array = cmd == OP_PAGE_PROGRAM || cmd == OP_PAGE_CLEAR
                    || cmd == OP_SECTOR_WIPE || cmd == OP_HALF_BLOCK_WIPE
                    || cmd == OP_BLOCK_WIPE;
  assign is_chip = cmd == OP_CHIP_WIPE_A || cmd == OP_CHIP_WIPE_B;
  assign is_sec = cmd == OP_SEC_PROGRAM || cmd == OP_SEC_CLEAR;
  assign is_single = cmd == OP_WRITE_ALLOW || cmd == OP_WRITE_DENY
                     || is_chip || cmd == OP_DEEP_SLEEP
                     || cmd == OP_SUSPEND_A || cmd == OP_SUSPEND_B
                     || cmd == OP_RESUME_A || cmd == OP_RESUME_B;
  // program frames carry data, so only a least length in whole bytes applies
  // status reads may end after any bit, so they are never discarded
  assign len_ok = cmd == OP_STATUS_RD_LO || cmd == OP_STATUS_RD_HI
      || cnt_ff[2:0] == 3'h0 && (
      (is_single && cnt_ff == LEN_1B)
   || (cmd == OP_WAKE)
   || (cmd == OP_STATUS_WRITE && (cnt_ff == LEN_2B || cnt_ff == LEN_3B))
   || ((cmd == OP_PAGE_PROGRAM || cmd == OP_SEC_PROGRAM)
       && cnt_ff >= LEN_5B)
   || ((is_array || cmd == OP_SEC_CLEAR) && cmd != OP_PAGE_PROGRAM
       && cnt_ff == LEN_4B));
  // security areas one to three sit at address bits 13..12
  assign sec_locked = addr[13:12] != 2'h0
                      && lock_ff[2'(addr[13:12] - 2'h1)];
  // status write permission per guard mode
  always_comb begin
    unique case (guard_ff)
      GUARD_SOFT: wr_allow = wel_ff;
      GUARD_PIN: wr_allow = wel_ff && wp_sync_ff;
      GUARD_POWER: wr_allow = 1'b0;
      GUARD_OTP: wr_allow = 1'b0;
    endcase
  end

  // one decoded, length-checked command per frame end
  logic exec;
  logic do_status;
  logic do_array;
  logic nxt_reject;
  assign exec = frame_end && len_ok && (!deep_sleep_ff || cmd == OP_WAKE);
  assign do_status = exec && cmd == OP_STATUS_WRITE && wr_allow
                     && !array_busy;
  assign do_array = exec && !array_busy && wel_ff && (
      (is_array && !tgt_hit)
   || (is_chip && !prot_any)
   || (is_sec && !sec_locked));
  assign nxt_reject = exec && (is_array || is_chip || is_sec
                               || cmd == OP_STATUS_WRITE)
                      && !do_array && !do_status;

  // status fields change only through an accepted status write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bp_ff <= RST_BP;
      guard_ff <= RST_GUARD;
      lock_ff <= RST_LOCK;
      cmp_ff <= RST_CMP;
    end else if (do_status) begin
      bp_ff <= addr[22:18];
      guard_ff[0] <= addr[23];
      if (cnt_ff == LEN_3B) begin
        guard_ff[1] <= addr[8];
        lock_ff <= lock_ff | addr[13:11];
        cmp_ff <= addr[14];
      end
    end
  end

  // write latch: set by write-allow, dropped after any accepted change
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wel_ff <= 1'b0;
    end else if (exec && cmd == OP_WRITE_ALLOW) begin
      wel_ff <= 1'b1;
    end else if ((exec && cmd == OP_WRITE_DENY) || do_status || do_array) begin
      wel_ff <= 1'b0;
    end
  end

  // suspend flags; resume clears both, reset models the power cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_sus_ff <= 1'b0;
      prog_sus_ff <= 1'b0;
    end else if (exec && (cmd == OP_RESUME_A || cmd == OP_RESUME_B)) begin
      erase_sus_ff <= 1'b0;
      prog_sus_ff <= 1'b0;
    end else if (exec && (cmd == OP_SUSPEND_A || cmd == OP_SUSPEND_B)
                 && array_busy) begin
      erase_sus_ff <= erase_sus_ff | array_erasing;
      prog_sus_ff <= prog_sus_ff | ~array_erasing;
    end
  end

  // deep sleep entry and release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deep_sleep_ff <= 1'b0;
    end else if (exec && cmd == OP_WAKE) begin
      deep_sleep_ff <= 1'b0;
    end else if (exec && cmd == OP_DEEP_SLEEP && !array_busy) begin
      deep_sleep_ff <= 1'b1;
    end
  end

  // outputs toward the array engine
  logic op_start_ff;
  logic [7:0] op_code_ff;
  logic [23:0] op_addr_ff;
  logic op_reject_ff;
  logic cmd_discard_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_start_ff <= 1'b0;
      op_code_ff <= 8'h00;
      op_addr_ff <= 24'h000000;
      op_reject_ff <= 1'b0;
      cmd_discard_ff <= 1'b0;
    end else begin
      op_start_ff <= do_array;
      op_reject_ff <= nxt_reject;
      cmd_discard_ff <= frame_end && !len_ok;
      if (do_array) begin
        op_code_ff <= cmd;
        op_addr_ff <= addr;
      end
    end
  end

  // status word snapshot; only refreshed between frames so the link
  // side never sees it move while it is shifting it out
  logic [15:0] status_now;
  assign status_now = {erase_sus_ff, cmp_ff, lock_ff, prog_sus_ff, 1'b0,
                       guard_ff[1], guard_ff[0], bp_ff, wel_ff, array_busy};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_hold_ff <= 16'h0000;
    end else if (cs_sync_ff && cs_prev_ff && link_ff == LS_STANDBY) begin
      status_hold_ff <= status_now;
    end
  end

  assign op_start = op_start_ff;
  assign op_code = op_code_ff;
  assign op_addr = op_addr_ff;
  assign op_reject = op_reject_ff;
  assign cmd_discard = cmd_discard_ff;
  assign deep_sleep = deep_sleep_ff;
  assign status_word = status_hold_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_latch_needed: assert property (op_start_ff |-> $past(wel_ff))
    else $error("array operation started without write latch");
  a_chip_wipe_guard: assert property (
    op_start_ff && (op_code_ff == OP_CHIP_WIPE_A
                    || op_code_ff == OP_CHIP_WIPE_B) |-> !$past(prot_any))
    else $error("chip wipe started with a guarded region");
  a_guarded_target: assert property (
    do_array && is_array |-> !tgt_hit)
    else $error("array operation accepted over guarded range");
  a_lock_sticky: assert property (
    (lock_ff & $past(lock_ff)) == $past(lock_ff))
    else $error("security lock bit cleared");
  a_pin_guard_hold: assert property (
    guard_ff == GUARD_PIN && !wp_sync_ff |=> $stable(bp_ff))
    else $error("select bits changed under pin guard");
  a_otp_guard_stay: assert property (
    guard_ff == GUARD_OTP |=> guard_ff == GUARD_OTP && $stable(lock_ff))
    else $error("permanent guard mode left");
  a_sleep_ignore: assert property (
    deep_sleep_ff |=> !op_start_ff && !$rose(wel_ff))
    else $error("command obeyed in deep sleep");
  a_short_frame: assert property (
    frame_end && !len_ok |=> cmd_discard_ff && !op_start_ff
                             && $stable(bp_ff) ##1 !cmd_discard_ff)
    else $error("bad length frame not discarded");
  a_resume_clear: assert property (
    exec && cmd == OP_RESUME_A |=> !erase_sus_ff && !prog_sus_ff)
    else $error("resume left a suspend flag set");

  c_array_start: cover property (op_start_ff);
  c_status_write: cover property (do_status && cnt_ff == LEN_3B);
  c_guard_reject: cover property (nxt_reject && is_array);
  c_sleep_wake: cover property ($fell(deep_sleep_ff));
endmodule

/* pkg/sfwp_pkg.sv */
// shared constants for the serial flash write-protection block
package sfwp_pkg;
  // memory geometry
  localparam int ADDR_W = 19;
  localparam logic [18:0] MEM_TOP = 19'h7FFFF;
  localparam int CNT_W = 12;
  // command codes
  localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
  localparam logic [7:0] OP_WRITE_DENY = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS_RD_LO = 8'h05;
  localparam logic [7:0] OP_STATUS_RD_HI = 8'h35;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_PAGE_CLEAR = 8'h81;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SEC_CLEAR = 8'h44;
  // status word bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_GUARD_LO = 7;
  localparam int ST_GUARD_HI = 8;
  localparam int ST_PROG_SUS = 10;
  localparam int ST_LOCK_LSB = 11;
  localparam int ST_CMP = 14;
  localparam int ST_ERASE_SUS = 15;
  // reset values of the protection fields
  localparam logic [4:0] RST_BP = 5'h00;
  localparam logic [1:0] RST_GUARD = 2'h0;
  localparam logic [2:0] RST_LOCK = 3'h0;
  localparam logic RST_CMP = 1'b0;
  // status-guard modes
  localparam logic [1:0] GUARD_SOFT = 2'h0;
  localparam logic [1:0] GUARD_PIN = 2'h1;
  localparam logic [1:0] GUARD_POWER = 2'h2;
  localparam logic [1:0] GUARD_OTP = 2'h3;
  // target sizes as log2 of bytes
  localparam logic [4:0] LG_PAGE = 5'd8;
  localparam logic [4:0] LG_SECTOR = 5'd12;
  localparam logic [4:0] LG_HALF_BLOCK = 5'd15;
  localparam logic [4:0] LG_BLOCK = 5'd16;
  // frame bit counts
  localparam logic [11:0] LEN_1B = 12'd8;
  localparam logic [11:0] LEN_2B = 12'd16;
  localparam logic [11:0] LEN_3B = 12'd24;
  localparam logic [11:0] LEN_4B = 12'd32;
  localparam logic [11:0] LEN_5B = 12'd40;
  // command state machine
  typedef enum logic [0:0] {
    LS_STANDBY = 1'b0,
    LS_ACTIVE = 1'b1
  } sfwp_link_t;
endpackage

/* testbench/sfwp_host.sv */
// host controller model for the serial link of the protection core
`timescale 1ns/1ns
module sfwp_host (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  // idle link: clock parked low, chip deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // one frame: nb bits msb first, then nrd clocks of read-back
  // sclk runs only inside the frame, 6 ns period
  task automatic frame(input logic [39:0] d, input int nb, input int nrd,
                       output logic [7:0] rd);
    rd = 8'h00;
    #1 cs_n = 1'b0; // keep chip select off the system clock edge
    #3;
    for (int i = 0; i < nb; i++) begin
      si = d[39 - i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    for (int i = 0; i < nrd; i++) begin
      si = ~si; // no stale value on a line the device ignores
      #3 sclk = 1'b1;
      rd = {rd[6:0], so_oe ? so : 1'bx}; // undriven output reads unknown
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the write-protection core
`timescale 1ns/1ns
module testbench;
  import sfwp_pkg::*;
  localparam logic [1:0] NONE = 2'h0;
  localparam logic [1:0] START = 2'h1;
  localparam logic [1:0] REJ = 2'h2;
  localparam logic [1:0] DISC = 2'h3;
  logic clk, reset_n, wp_n, array_busy, array_erasing;
  logic sclk, cs_n, si, so, so_oe, op_start, op_reject, cmd_discard;
  logic deep_sleep;
  logic [7:0] op_code;
  logic [23:0] op_addr;
  logic [15:0] status_word;
  logic [1:0] seen;
  logic [7:0] rd;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] sus [2] = '{OP_SUSPEND_A, OP_SUSPEND_B};
  logic [7:0] res [2] = '{OP_RESUME_A, OP_RESUME_B};
  logic [15:0] pl [2] = '{16'h0100, 16'h0180};
  // protect setting, opcode, target, outcome
  logic [49:0] tab [16] = '{
    {16'h0004, OP_SECTOR_WIPE, 24'h070000, REJ},
    {16'h0004, OP_PAGE_PROGRAM, 24'h06FF00, START},
    {16'h0028, OP_PAGE_CLEAR, 24'h01FF00, REJ},
    {16'h0028, OP_BLOCK_WIPE, 24'h020000, START},
    {16'h0010, OP_SECTOR_WIPE, 24'h000000, REJ},
    {16'h0044, OP_SECTOR_WIPE, 24'h07F000, REJ},
    {16'h0044, OP_SECTOR_WIPE, 24'h07E000, START},
    {16'h0044, OP_BLOCK_WIPE, 24'h070000, REJ},
    {16'h0044, OP_CHIP_WIPE_B, 24'h000000, REJ},
    {16'h007C, OP_HALF_BLOCK_WIPE, 24'h040000, REJ},
    {16'h4004, OP_SECTOR_WIPE, 24'h06F000, REJ},
    {16'h4004, OP_SECTOR_WIPE, 24'h070000, START},
    {16'h4000, OP_SECTOR_WIPE, 24'h070000, REJ},
    {16'h0000, OP_CHIP_WIPE_A, 24'h000000, START},
    {16'h0800, OP_SEC_PROGRAM, 24'h001000, REJ},
    {16'h0800, OP_SEC_PROGRAM, 24'h002000, START}
  };

  sfwp_prot sfwp_prot_inst (.clk(clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
    .array_busy(array_busy), .array_erasing(array_erasing),
    .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
    .op_reject(op_reject), .cmd_discard(cmd_discard),
    .deep_sleep(deep_sleep), .status_word(status_word));
  sfwp_host sfwp_host_inst (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));

  // 125 MHz system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // remember which one-cycle answer pulse came for the current frame
  always @(posedge clk) begin
    if (op_start) seen <= START;
    if (op_reject) seen <= REJ;
    if (cmd_discard) seen <= DISC;
  end

  task automatic check(input string what, input logic [23:0] got,
                       input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // reset is also a power cycle; 3 edges before the next frame
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // one frame, then 8 clocks: the answer lands within 4, gap stays >= 4
  task automatic cmd(input string what, input logic [39:0] d,
                     input int nb, input int nrd, input logic [1:0] exp);
    @(posedge clk);
    seen <= NONE;
    sfwp_host_inst.frame(d, nb, nrd, rd);
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(what, 24'(seen), 24'(exp));
  endtask

  task automatic write_allow_cmd();
    cmd("write allow", {OP_WRITE_ALLOW, 32'h0}, 8, 0, NONE);
  endtask

  task automatic wsr(input string what, input logic [15:0] v,
                     input logic [1:0] exp);
    write_allow_cmd();
    cmd(what, {OP_STATUS_WRITE, v[7:0], v[15:8], 16'h0}, 24, 0, exp);
  endtask

  task automatic arr(input logic [7:0] op, input logic [23:0] a,
                     input logic [1:0] exp);
    int nb;
    nb = (op == OP_PAGE_PROGRAM || op == OP_SEC_PROGRAM) ? 40 : 32;
    if (op == OP_CHIP_WIPE_A || op == OP_CHIP_WIPE_B) nb = 8;
    write_allow_cmd();
    cmd("array op", {op, a, 8'h00}, nb, 0, exp);
    if (exp == START && nb != 8) begin
      check("op_code", 24'(op_code), 24'(op));
      check("op_addr", op_addr, a);
    end
  endtask

  // watchdog, far beyond the expected run of some 17 us
  initial begin
    #400000;
    fails++;
    end_sim();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    array_busy = 1'b0;
    array_erasing = 1'b0;
    seen = NONE;
    do_reset();
    check("reset status", 24'(status_word), 24'h0);
    $display("test reset done");
    cmd("no latch", {OP_STATUS_WRITE, 32'h0400_0000}, 24, 0, REJ);
    cmd("short", {OP_WRITE_ALLOW, 32'h0}, 7, 0, DISC);
    cmd("ragged", {OP_STATUS_WRITE, 32'h0}, 12, 0, DISC);
    check("status held", 24'(status_word), 24'h0);
    $display("test length done");
    foreach (tab[i]) begin
      wsr("status write", tab[i][49:34], NONE);
      check("status_word", 24'(status_word), 24'(tab[i][49:34]));
      arr(tab[i][33:26], tab[i][25:2], tab[i][1:0]);
    end
    wsr("lock clear", 16'h0000, NONE);
    check("lock kept", 24'(status_word), 24'h0800);
    cmd("read high", {OP_STATUS_RD_HI, 32'h0}, 8, 8, NONE);
    check("read high", 24'(rd), 24'h08);
    $display("test protect done");
    @(posedge clk);
    wp_n <= 1'b0;
    wsr("soft pin low", 16'h0084, NONE);
    cmd("read low", {OP_STATUS_RD_LO, 32'h0}, 8, 8, NONE);
    check("read low", 24'(rd), 24'h84);
    wsr("pin locked", 16'h0000, REJ);
    check("bp frozen", 24'(status_word), 24'h0886);
    @(posedge clk);
    wp_n <= 1'b1;
    wsr("pin high", 16'h0000, NONE);
    check("bp written", 24'(status_word), 24'h0800);
    $display("test pin guard done");
    foreach (sus[i]) begin
      @(posedge clk);
      array_busy <= 1'b1;
      array_erasing <= (i == 0);
      cmd("suspend", {sus[i], 32'h0}, 8, 0, NONE);
      check("suspend", 24'(status_word), i ? 24'h0C01 : 24'h8801);
      cmd("resume", {res[i], 32'h0}, 8, 0, NONE);
      check("resume", 24'(status_word), 24'h0801);
    end
    @(posedge clk);
    array_busy <= 1'b0;
    $display("test suspend done");
    cmd("sleep", {OP_DEEP_SLEEP, 32'h0}, 8, 0, NONE);
    check("deep_sleep", 24'(deep_sleep), 24'h1);
    cmd("asleep write", {OP_STATUS_WRITE, 32'h0}, 24, 0, NONE);
    write_allow_cmd();
    check("latch asleep", 24'(status_word), 24'h0800);
    cmd("wake", {OP_WAKE, 32'h0}, 8, 0, NONE);
    check("awake", 24'(deep_sleep), 24'h0);
    write_allow_cmd();
    check("latch set", 24'(status_word), 24'h0802);
    cmd("write deny", {OP_WRITE_DENY, 32'h0}, 8, 0, NONE);
    check("latch dropped", 24'(status_word), 24'h0800);
    $display("test sleep done");
    do_reset();
    check("power cycle", 24'(status_word), 24'h0);
    foreach (pl[i]) begin
      wsr("guard set", pl[i], NONE);
      check("guard", 24'(status_word), 24'(pl[i]));
      wsr("guard locked", 16'h0000, REJ);
      do_reset();
      check("after power", 24'(status_word), 24'h0);
    end
    $display("test power lock done");
    end_sim();
  end
endmodule
